// ### logic/pbss_pkg.sv
// constants and carrier types for the pipelined burst sync memory
`default_nettype none
package pbss_pkg;
    // array shape
    localparam int PBSS_WORDS = 65536;
    localparam int PBSS_ADDR_W = 16;
    localparam int PBSS_DATA_W = 36;
    localparam int PBSS_LANES = 4;
    localparam int PBSS_BURST_W = 2;
    // reset values
    localparam logic [1:0] PBSS_CNT_RST = 2'h0;
    localparam logic PBSS_STATIC_RST = 1'h1; // static pins rest high
    localparam logic [2:0] PBSS_SYNC_RST = 3'h7;
    // synchroniser stage positions
    localparam int PBSS_SYNC_SECOND = 1;
    localparam int PBSS_SYNC_THIRD = 2;

    // address strobes and burst advance, all active low
    typedef struct packed {
        logic proc_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_advance_n;
    } pbss_strobe_t;

    // the three chip selects
    typedef struct packed {
        logic master_select_n;
        logic second_select_hi;
        logic third_select_n;
    } pbss_select_t;

    // write command group
    typedef struct packed {
        logic all_bytes_write_n;
        logic byte_write_gate_n;
        logic [PBSS_LANES-1:0] lane_write_bus_n;
    } pbss_write_t;

    // what the previous edge set up
    typedef enum logic [1:0] {PBSS_IDLE, PBSS_READ, PBSS_WRITE} pbss_cyc_t;
endpackage
`default_nettype wire

// ### logic/pbss_sram.sv
// pipelined burst synchronous static memory, host-facing logic and array
// Operation
// - 65,536 words of 32/36 bits; address and output register stages on rising edge.
// - processor strobe low with all selects active loads address, starts a read.
// - read data of a registered address reaches the pins at the next edge.
// - advance ignored on processor-strobe edge; low with strobes high steps burst.
// - order select high or open gives xor order; low gives linear order.
// - global write enable low writes every lane of the word.
// - otherwise lanes write only when gate low and lane low; else read.
// - lane writes ignored on processor-strobe edge, sampled on later edges.
// - any lane write sampled low turns the data drivers off.
// - data pins captured into input register when a lane write is low.
// - write burst steps the address when lane write and advance are low.
// - controller-strobe cycle samples write enables on its starting edge.
// - inactive master select blocks processor starts, not controller starts.
// - data pins driven only with output enable active during a read.
// - second select active high, third active low, sampled on start edges.
// - single-stage select low bypasses output register stage; high is pipelined.
`timescale 1ns/1ps
`default_nettype none
module pbss_sram
    import pbss_pkg::*;
#(
    parameter int DATA_W = PBSS_DATA_W,
    parameter int ADDR_W = PBSS_ADDR_W,
    parameter int WORDS = PBSS_WORDS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // synchronous bus
    input wire logic [ADDR_W-1:0] addr,
    input wire pbss_strobe_t strobe,
    input wire pbss_select_t select,
    input wire pbss_write_t wr_ctl,
    // static and asynchronous pins
    input wire logic output_enable_n,
    input wire logic burst_order_sel_n,
    input wire logic single_stage_sel_n,
    // data pins
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe
);
    localparam int LANE_W = DATA_W / PBSS_LANES;
    localparam int UP_W = ADDR_W - PBSS_BURST_W;

    // burst low bits: xor walk or linear walk, wrapping in the group
    function automatic logic [PBSS_BURST_W-1:0] burst_low(
        input logic [PBSS_BURST_W-1:0] base,
        input logic [PBSS_BURST_W-1:0] cnt,
        input logic xor_mode);
        burst_low = xor_mode ? (base ^ cnt) : PBSS_BURST_W'(base + cnt);
    endfunction

    // lane-wise merge of new data over an old word
    function automatic logic [DATA_W-1:0] lane_merge(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [PBSS_LANES-1:0] mask);
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int i = 0; i < PBSS_LANES; i++) begin
            if (mask[i]) begin
                res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
        lane_merge = res;
    endfunction

    // storage array, not reset
    logic [DATA_W-1:0] mem [WORDS];

    // three-stage synchronisers for the pins outside the bus timing
    logic [2:0] oe_s_q;
    logic [2:0] lbo_s_q;
    logic [2:0] ft_s_q;
    logic oe_n_q;
    logic xor_mode_q;
    logic pipelined_q;

    // address, burst and cycle state
    logic [ADDR_W-1:0] base_q;
    logic [ADDR_W-1:0] base_d;
    logic [PBSS_BURST_W-1:0] cnt_q;
    logic [PBSS_BURST_W-1:0] cnt_d;
    pbss_cyc_t cyc_q;
    pbss_cyc_t cyc_d;

    // input data register and pending write
    logic [DATA_W-1:0] din_q;
    logic wr_pend_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [PBSS_LANES-1:0] wr_mask_q;
    logic dvalid_q;

    // decoded bus terms
    logic sel_ok;
    logic proc_start;
    logic ctrl_start;
    logic any_strobe;
    logic cont;
    logic [PBSS_LANES-1:0] lanes_low;
    logic lane_seen;
    logic wr_cmd;
    logic wr_now;
    logic [PBSS_LANES-1:0] wr_mask;
    logic [ADDR_W-1:0] cur_eff;
    logic [ADDR_W-1:0] next_eff;
    logic [ADDR_W-1:0] rd_addr;
    logic rd_load;
    logic [DATA_W-1:0] mem_word;

    // pins are static or asynchronous, so settle before use
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            oe_s_q <= PBSS_SYNC_RST;
            lbo_s_q <= PBSS_SYNC_RST;
            ft_s_q <= PBSS_SYNC_RST;
        end else begin
            oe_s_q <= {oe_s_q[1:0], output_enable_n};
            lbo_s_q <= {lbo_s_q[1:0], burst_order_sel_n};
            ft_s_q <= {ft_s_q[1:0], single_stage_sel_n};
        end
    end

    // accept a level only once second and third stages agree
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            oe_n_q <= PBSS_STATIC_RST;
            xor_mode_q <= PBSS_STATIC_RST;
            pipelined_q <= PBSS_STATIC_RST;
        end else begin
            if (oe_s_q[PBSS_SYNC_SECOND] == oe_s_q[PBSS_SYNC_THIRD]) begin
                oe_n_q <= oe_s_q[PBSS_SYNC_THIRD];
            end
            if (lbo_s_q[PBSS_SYNC_SECOND] == lbo_s_q[PBSS_SYNC_THIRD]) begin
                xor_mode_q <= lbo_s_q[PBSS_SYNC_THIRD];
            end
            if (ft_s_q[PBSS_SYNC_SECOND] == ft_s_q[PBSS_SYNC_THIRD]) begin
                pipelined_q <= ft_s_q[PBSS_SYNC_THIRD];
            end
        end
    end

    // start, continue and write decode for this edge
    always_comb begin
        sel_ok = select.second_select_hi & ~select.third_select_n;
        proc_start = ~strobe.proc_addr_strobe_n & ~select.master_select_n & sel_ok;
        ctrl_start = ~strobe.ctrl_addr_strobe_n & strobe.proc_addr_strobe_n & sel_ok;
        any_strobe = ~strobe.proc_addr_strobe_n | ~strobe.ctrl_addr_strobe_n;
        cont = ~any_strobe & (cyc_q != PBSS_IDLE);
        lanes_low = ~wr_ctl.lane_write_bus_n;
        lane_seen = ~proc_start & (|lanes_low);
        wr_cmd = ~wr_ctl.all_bytes_write_n | (~wr_ctl.byte_write_gate_n & (|lanes_low));
        if (!wr_ctl.all_bytes_write_n) begin
            wr_mask = '1;
        end else if (!wr_ctl.byte_write_gate_n) begin
            wr_mask = lanes_low;
        end else begin
            wr_mask = '0;
        end
        wr_now = (ctrl_start | cont) & wr_cmd;
    end

    // effective addresses before and after this edge
    always_comb begin
        cur_eff = {base_q[ADDR_W-1 -: UP_W], burst_low(base_q[PBSS_BURST_W-1:0], cnt_q, xor_mode_q)};
        next_eff = {base_d[ADDR_W-1 -: UP_W], burst_low(base_d[PBSS_BURST_W-1:0], cnt_d, xor_mode_q)};
    end

    // next address register and burst count
    always_comb begin
        base_d = base_q;
        cnt_d = cnt_q;
        if (proc_start || ctrl_start) begin
            base_d = addr;
            cnt_d = PBSS_CNT_RST;
        end else if (cont && !strobe.burst_advance_n) begin
            cnt_d = PBSS_BURST_W'(cnt_q + 1'b1);
        end
    end

    // cycle kind set up by this edge
    always_comb begin
        case (cyc_q)
            PBSS_IDLE, PBSS_READ, PBSS_WRITE: begin
                if (proc_start || ctrl_start) begin
                    cyc_d = wr_now ? PBSS_WRITE : PBSS_READ;
                end else if (any_strobe || cyc_q == PBSS_IDLE) begin
                    cyc_d = PBSS_IDLE; // deselect or stay idle
                end else begin
                    cyc_d = wr_now ? PBSS_WRITE : PBSS_READ;
                end
            end
            default: cyc_d = PBSS_IDLE;
        endcase
    end

    // address register stage
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            base_q <= '0;
            cnt_q <= PBSS_CNT_RST;
            cyc_q <= PBSS_IDLE;
        end else begin
            base_q <= base_d;
            cnt_q <= cnt_d;
            cyc_q <= cyc_d;
        end
    end

    // input data register; the array is written one edge later
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            din_q <= '0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            wr_mask_q <= '0;
        end else begin
            if (wr_now || lane_seen) begin
                din_q <= dq_in;
            end
            wr_pend_q <= wr_now;
            wr_addr_q <= ctrl_start ? addr : cur_eff;
            wr_mask_q <= wr_mask;
        end
    end

    // commit pending write into the array
    always_ff @(posedge clk_sys) begin
        if (wr_pend_q) begin
            mem[wr_addr_q] <= lane_merge(mem[wr_addr_q], din_q, wr_mask_q);
        end
    end

    // read word with forwarding, so a read right after a write sees it
    always_comb begin
        rd_addr = pipelined_q ? cur_eff : next_eff;
        rd_load = pipelined_q ? (cyc_q == PBSS_READ) : (cyc_d == PBSS_READ);
        mem_word = mem[rd_addr];
        if (wr_pend_q && wr_addr_q == rd_addr) begin
            mem_word = lane_merge(mem_word, din_q, wr_mask_q);
        end
    end

    // output data register and driver enable
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dq_out <= '0;
            dvalid_q <= 1'b0;
            dq_oe <= 1'b0;
        end else begin
            if (rd_load) begin
                dq_out <= mem_word;
            end
            dvalid_q <= rd_load;
            // enable sees oe four edges late; controller must allow for it
            dq_oe <= ~oe_n_q & rd_load & ~lane_seen & ~wr_now;
        end
    end

    // checks next to the logic
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence seq_proc_edge;
        proc_start;
    endsequence

    sequence seq_burst_edge;
        cont && !strobe.burst_advance_n;
    endsequence

    sequence seq_pipe_read;
        pipelined_q && cyc_q == PBSS_READ && $stable(pipelined_q);
    endsequence

    chk_proc_addr_load: assert property (seq_proc_edge |=> base_q == $past(addr) && cnt_q == PBSS_CNT_RST)
        else $error("processor strobe did not load address");
    chk_adv_ignored: assert property (seq_proc_edge ##1 !any_strobe && strobe.burst_advance_n |=> cnt_q == 2'h0)
        else $error("burst count moved without advance");
    chk_burst_step: assert property (seq_burst_edge |=> cnt_q == PBSS_BURST_W'($past(cnt_q) + 1'b1))
        else $error("burst count did not step");
    chk_pipe_valid: assert property (seq_pipe_read |=> dvalid_q ##1 1'b1)
        else $error("pipelined read data not loaded");
    chk_global_write: assert property (cont && !wr_ctl.all_bytes_write_n |=> wr_pend_q && wr_mask_q == '1)
        else $error("global write did not cover all lanes");
    chk_gate_read: assert property (cont && wr_ctl.all_bytes_write_n && wr_ctl.byte_write_gate_n |=> !wr_pend_q)
        else $error("write happened with gate high");
    chk_lane_ignore: assert property (seq_proc_edge |=> !wr_pend_q)
        else $error("lane write taken on processor strobe edge");
    chk_lane_off: assert property (lane_seen |=> !dq_oe)
        else $error("drivers on while lane write low");
    chk_din_capture: assert property (lane_seen |=> din_q == $past(dq_in))
        else $error("input register missed data");
    chk_master_block: assert property (!strobe.proc_addr_strobe_n && select.master_select_n
        && strobe.ctrl_addr_strobe_n |=> cyc_q == PBSS_IDLE)
        else $error("processor start not blocked");
    chk_ctrl_start: assert property (ctrl_start && !wr_cmd |=> cyc_q == PBSS_READ && base_q == $past(addr))
        else $error("controller start not taken");
    chk_drive_gate: assert property (dq_oe |-> !$past(oe_n_q) && dvalid_q)
        else $error("drivers on outside an enabled read");
    chk_wrap_group: assert property (seq_burst_edge |=> base_q[ADDR_W-1 -: UP_W] == $past(base_q[ADDR_W-1 -: UP_W]))
        else $error("burst left its aligned group");
    chk_sel_sample: assert property (any_strobe && !sel_ok |=> cyc_q == PBSS_IDLE)
        else $error("start taken with secondary select inactive");
    chk_flow_valid: assert property (!pipelined_q && $stable(pipelined_q) && cyc_d == PBSS_READ |=> dvalid_q)
        else $error("single-stage read not loaded at once");
    chk_xor_order: assert property (seq_burst_edge and (xor_mode_q && $stable(xor_mode_q)) |=>
        cur_eff[1:0] == (base_q[1:0] ^ cnt_q))
        else $error("xor burst order wrong");
endmodule // pbss_sram
`default_nettype wire

// ### bench/pbss_host_model.sv
// behavioural bus controller facing the burst memory, with the data wire
`timescale 1ns/1ps
`default_nettype none
module pbss_host_model
    import pbss_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // bus towards the memory
    output logic [PBSS_ADDR_W-1:0] addr,
    output pbss_strobe_t strobe,
    output pbss_select_t select,
    output pbss_write_t wr_ctl,
    output logic output_enable_n,
    // data wire
    output logic [PBSS_DATA_W-1:0] dq_in,
    input wire logic [PBSS_DATA_W-1:0] dq_out,
    input wire logic dq_oe
);
    logic drv_en = 1'b0;
    logic [PBSS_DATA_W-1:0] drv_d = '0;
    logic [PBSS_DATA_W-1:0] last_q = '0;
    int oe_age = 0;
    initial begin
        addr = 16'h0;
        strobe = 3'h7;
        select = 3'h2;
        wr_ctl = 6'h3f;
        output_enable_n = 1'b1;
    end
    // released wire flips every cycle so a stale value never reads back
    always_comb dq_in = drv_en ? drv_d : (dq_oe ? dq_out : ~last_q);
    always_ff @(posedge clk_sys) last_q <= dq_in;
    // edges since output enable last moved
    always @(posedge clk_sys) oe_age++;
    // one bus edge: change after falling edge, hold through the rising edge
    task automatic bus_edge(input logic [15:0] a, input pbss_strobe_t s, input pbss_select_t c,
                            input pbss_write_t w, input logic [35:0] d);
        pbss_strobe_t sv;
        sv = s;
        if (!s.ctrl_addr_strobe_n) sv.proc_addr_strobe_n = 1'b1;
        @(negedge clk_sys);
        addr = a;
        strobe = sv;
        select = c;
        wr_ctl = w;
        drv_d = d;
        drv_en = !w.all_bytes_write_n || (!w.byte_write_gate_n && w.lane_write_bus_n != 4'hf);
        @(posedge clk_sys);
        #1;
    endtask
    task automatic set_oe(input logic v);
        @(negedge clk_sys);
        output_enable_n = v;
        oe_age = 0;
    endtask
    // output buffers off and settled before the controller-started write burst is issued
    task automatic write_prep();
        set_oe(1'b1);
        repeat (5) bus_edge(addr, 3'h7, select, 6'h3f, 36'h0);
    endtask
endmodule // pbss_host_model
`default_nettype wire

// ### bench/pipelined_burst_sync_sram_bench.sv
// self-checking bench for the burst memory with a reference array
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sync_sram_bench import pbss_pkg::*;;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic order_n = 1'b1;
    logic single_n = 1'b1;
    logic [15:0] addr;
    pbss_strobe_t strobe;
    pbss_select_t select;
    pbss_write_t wr_ctl;
    logic output_enable_n;
    logic [35:0] dq_in;
    logic [35:0] dq_out;
    logic dq_oe;
    logic [35:0] ref_mem [int];
    logic [15:0] base = 16'h0;
    logic [1:0] cnt = 2'h0;
    logic [15:0] a;
    // dq_out after an edge carries the read that the edge before set up
    logic rd_prev = 1'b0;
    int fail_count = 0;
    int n_compared = 0;
    pbss_select_t bad_sel [4] = '{3'h6, 3'h0, 3'h3, 3'h6};

    always #25 clk_sys = ~clk_sys;

    pbss_sram uut (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .strobe(strobe), .select(select),
        .wr_ctl(wr_ctl), .output_enable_n(output_enable_n), .burst_order_sel_n(order_n),
        .single_stage_sel_n(single_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
    pbss_host_model host (.clk_sys(clk_sys), .addr(addr), .strobe(strobe), .select(select),
        .wr_ctl(wr_ctl), .output_enable_n(output_enable_n), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe));

    // burst address from base and count, upper bits fixed
    function automatic logic [15:0] baddr(logic [15:0] b, logic [1:0] c, logic x);
        return {b[15:2], x ? (b[1:0] ^ c) : (b[1:0] + c)};
    endfunction
    // lane i covers bits 9i+8..9i
    function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] m);
        logic [35:0] r;
        r = o;
        for (int i = 0; i < 4; i++) if (!m[i]) r[9*i +: 9] = n[9*i +: 9];
        return r;
    endfunction
    function automatic logic [35:0] rnd36();
        return {4'($urandom), 32'($urandom)};
    endfunction
    task automatic check(input string name, input logic [35:0] exp, input logic [35:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    // start edge; address bus carries a, the count restarts on a valid start
    task automatic start(input logic proc, input logic [15:0] sa, input pbss_select_t c,
                         input pbss_write_t w, input logic [35:0] d);
        logic ok;
        ok = c.second_select_hi && !c.third_select_n && (!proc || !c.master_select_n);
        host.bus_edge(sa, proc ? 3'h2 : 3'h5, c, w, d);
        if (ok) begin
            base = sa;
            cnt = 2'h0;
            if (!proc && !w.all_bytes_write_n) ref_mem[sa] = d;
        end
        rd_prev = ok && (proc || (w.all_bytes_write_n && (w.byte_write_gate_n || w.lane_write_bus_n == 4'hf)));
        // the tail of an earlier read may still drive on the deselect edge itself
        if (!ok) host.bus_edge(sa, 3'h7, c, 6'h3f, 36'h0);
        if (!ok) check("dq_oe deselect", 36'h0, {35'h0, dq_oe});
        if (ok && proc && !single_n) check("dq_out single", ref_mem[sa], dq_out);
    endtask
    // continue edge; a random address on the bus must not matter
    task automatic cont(input logic adv_n, input pbss_write_t w, input logic [35:0] d);
        logic [15:0] cur;
        logic wr;
        cur = baddr(base, cnt, order_n);
        wr = !w.all_bytes_write_n || (!w.byte_write_gate_n && w.lane_write_bus_n != 4'hf);
        host.bus_edge(16'($urandom), {2'h3, adv_n}, 3'h2, w, d);
        if (wr) ref_mem[cur] = w.all_bytes_write_n ? merge(ref_mem[cur], d, w.lane_write_bus_n) : d;
        if (wr) check("dq_oe write", 36'h0, {35'h0, dq_oe});
        if (!wr && rd_prev) check("dq_out", ref_mem[cur], dq_out);
        // output enable needs four edges through its synchroniser
        if (!wr && rd_prev && host.oe_age >= 5) check("dq_oe read", {35'h0, !output_enable_n}, {35'h0, dq_oe});
        if (!adv_n) cnt++;
        rd_prev = !wr;
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // watchdog at 4000 clock periods, far beyond the roughly 135 edges the tests need
    initial begin
        #(50 * 4000);
        fail_count++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h040b));
        repeat (6) @(negedge clk_sys);
        check("dq_oe reset", 36'h0, {35'h0, dq_oe});
        nrst = 1'b1;
        for (int k = 0; k < 4; k++) begin
            order_n = k[0];
            a = 16'($urandom);
            host.write_prep();
            start(1'b0, a, 3'h6, 6'h1f, rnd36());
            repeat (4) cont(1'b0, 6'h1f, rnd36());
            cont(1'b0, {2'h2, 4'($urandom % 15)}, rnd36());
            cont(1'b1, 6'h30, rnd36());
            host.set_oe(1'b0);
            repeat (5) cont(1'b1, 6'h3f, 36'h0);
            start(1'b1, a, 3'h2, 6'h00, rnd36());
            cont(1'b1, 6'h3f, 36'h0);
            repeat (4) cont(1'b0, 6'h3f, 36'h0);
            cont(1'b1, 6'h2e, rnd36());
            repeat (2) cont(1'b1, 6'h3f, 36'h0);
            start(1'b1, a, bad_sel[k], 6'h3f, 36'h0);
        end
        // controller-started read with master select inactive
        start(1'b0, a, 3'h6, 6'h3f, 36'h0);
        cont(1'b1, 6'h3f, 36'h0);
        // single register mode needs the static pin settled first
        single_n = 1'b0;
        repeat (5) host.bus_edge(16'h0, 3'h7, 3'h2, 6'h3f, 36'h0);
        start(1'b1, a, 3'h2, 6'h3f, 36'h0);
        single_n = 1'b1;
        complete_run();
    end
endmodule // pipelined_burst_sync_sram_bench
`default_nettype wire
